// File: include/twe_pkg.sv
// Purpose: shared constants and types of the two-wire memory target write path
// Assumes: system clock of 20 MHz; serial clock comes from the bus controller
// Notes:   timing counts derive from the printed time and the clock rate
package twe_pkg;

    // system clock rate and the longest internal program time
    localparam int SYS_CLK_KHZ        = 20000;
    localparam int PROG_TIME_US       = 5000;
    localparam int PROG_CYC           = (PROG_TIME_US * SYS_CLK_KHZ) / 1000;

    // system cycles between the stop on the pins and its edge in the system domain
    localparam int STOP_LAT           = 3;

    // word and address geometry
    localparam int BYTE_W             = 8;
    localparam int PAGE_BYTES         = 64;
    localparam int OFF_W              = 6;
    localparam int PAGE_W             = 9;
    localparam int ADDR_W             = 15;
    localparam int ADDR_HI_W          = ADDR_W - BYTE_W;
    localparam int STRAP_W            = 3;
    localparam int CNT_W              = 4;

    // device address word layout
    localparam logic [3:0] DEV_CODE   = 4'ha;
    localparam int DEV_CODE_MSB       = 7;
    localparam int DEV_CODE_LSB       = 4;
    localparam int STRAP_MSB          = 3;
    localparam int STRAP_LSB          = 1;
    localparam int RW_BIT             = 0;

    // bit counter values: last data bit and the acknowledge clock
    localparam logic [CNT_W-1:0] LAST_BIT_CNT = 4'h7;
    localparam logic [CNT_W-1:0] ACK_BIT_CNT  = 4'h8;

    // protocol engine on the serial clock
    typedef enum logic [2:0]
    {
        LS_IDLE    = 3'b000,
        LS_DEV     = 3'b001,
        LS_ADDR_HI = 3'b010,
        LS_ADDR_LO = 3'b011,
        LS_DATA    = 3'b100
    } twe_link_e;

    // internal program cycle on the system clock
    typedef enum logic [1:0]
    {
        SS_IDLE = 2'b00,
        SS_COPY = 2'b01,
        SS_WAIT = 2'b10
    } twe_prog_e;

endpackage

// File: design/twe_sync.sv
// Purpose: two-stage synchroniser for a group of levels
// Assumes: each bit is a level or a toggle that stays put for several clocks
// Notes:   bits are synchronised one by one, so multi-bit words must not pass here
module twe_sync
#(
    parameter int W = 1
)
(
    input  wire logic         i_clk,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    logic [W-1:0] meta_q;

    generate
        if (W < 1)
        begin : g_chk
            $error("twe_sync: width must be at least one");
        end
    endgenerate

    // first stage is read by the second stage only
    always_ff @(posedge i_clk)
    begin
        meta_q <= i_d;
        o_q    <= meta_q;
    end

endmodule

// File: design/twe_target.sv
// Purpose: target side of the two-wire serial memory: framing, address match,
//          byte and page writes and the self-timed program cycle
// Assumes: serial clock is a clock port; data line edges clock the start and
//          stop detectors; read transfers are handled elsewhere
// Notes:   open-drain data line is split into input, output and enable
module twe_target
    import twe_pkg::*;
#(
    parameter int P_PROG_CYC = PROG_CYC
)
(
    input  wire logic               i_clk_sys,
    input  wire logic               i_rst_n,
    input  wire logic               i_scl,
    input  wire logic               i_sda_i,
    input  wire logic [STRAP_W-1:0] i_chip_select_straps,
    input  wire logic               i_write_protect,
    output logic                    o_sda_o,
    output logic                    o_sda_oe,
    output logic                    o_prog_busy,
    output logic                    o_standby
);

    localparam int BUSY_CYC = P_PROG_CYC - STOP_LAT;

    generate
        if (P_PROG_CYC <= PAGE_BYTES + STOP_LAT + 1)
        begin : g_chk
            $error("twe_target: program time too short to copy one page");
        end
    endgenerate

    // data-line clocked framing detectors
    logic                    start_tog_q;
    logic                    stop_tog_q;

    // serial clock domain
    logic                    rst_l_n;
    logic                    busy_l;
    logic [STRAP_W-1:0]      straps_l;
    logic                    start_seen_q;
    twe_link_e               state_q;
    logic [6:0]              shreg_q;
    logic [CNT_W-1:0]        cnt_q;
    logic                    ack_q;
    logic                    armed_q;
    logic [ADDR_HI_W-1:0]    addr_hi_q;
    logic [PAGE_W-1:0]       page_q;
    logic [OFF_W-1:0]        off_q;
    logic [PAGE_BYTES-1:0]   mask_q;
    logic [BYTE_W-1:0]       buf_q [0:PAGE_BYTES-1];
    logic                    sda_oe_q;
    logic                    new_start;
    logic                    byte_done;
    logic [BYTE_W-1:0]       byte_w;

    // system clock domain
    logic                    start_s;
    logic                    stop_s;
    logic                    armed_s;
    logic                    wp_s;
    logic                    start_prev_q;
    logic                    stop_prev_q;
    logic                    start_ev;
    logic                    stop_ev;
    twe_prog_e               prog_q;
    logic                    busy_q;
    logic [16:0]             tmr_q;
    logic [OFF_W-1:0]        idx_q;
    logic                    frame_open_q;
    logic                    standby_q;
    logic                    sda_o_q;
    logic [BYTE_W-1:0]       mem_q [0:(1 << ADDR_W)-1];

    function automatic logic dev_match(input logic [BYTE_W-1:0] b,
                                       input logic [STRAP_W-1:0] s);
        dev_match = (b[DEV_CODE_MSB:DEV_CODE_LSB] == DEV_CODE)
                 && (b[STRAP_MSB:STRAP_LSB] == s);
    endfunction

    generate
        if (BUSY_CYC > (1 << 17))
        begin : g_tmr_chk
            $error("twe_target: program time exceeds the timer width");
        end
    endgenerate

    // start and stop are data edges while the clock is high
    always_ff @(negedge i_sda_i)
    begin
        if (!i_rst_n)
        begin
            start_tog_q <= 1'b0;
        end
        else if (i_scl)
        begin
            start_tog_q <= ~start_tog_q;
        end
    end

    always_ff @(posedge i_sda_i)
    begin
        if (!i_rst_n)
        begin
            stop_tog_q <= 1'b0;
        end
        else if (i_scl)
        begin
            stop_tog_q <= ~stop_tog_q;
        end
    end

    // reset, straps and program-busy brought onto the serial clock
    twe_sync #(.W(1)) u_rst_l
    (
        .i_clk (i_scl),
        .i_d   (i_rst_n),
        .o_q   (rst_l_n)
    );

    twe_sync #(.W(STRAP_W + 1)) u_link_sync
    (
        .i_clk (i_scl),
        .i_d   ({busy_q, i_chip_select_straps}),
        .o_q   ({busy_l, straps_l})
    );

    // the start toggle settles a full start hold time before the next rising clock
    assign new_start = start_tog_q ^ start_seen_q;
    assign byte_done = !new_start && (cnt_q == LAST_BIT_CNT);
    assign byte_w    = {shreg_q, i_sda_i};

    // protocol engine: bits enter on the rising serial clock
    always_ff @(posedge i_scl)
    begin
        if (!rst_l_n)
        begin
            start_seen_q <= start_tog_q;
            state_q      <= LS_IDLE;
            shreg_q      <= 7'h00;
            cnt_q        <= 4'h0;
            ack_q        <= 1'b0;
            armed_q      <= 1'b0;
            addr_hi_q    <= 7'h00;
        end
        else if (new_start)
        begin
            // any start, also mid-frame, opens a fresh transfer
            start_seen_q <= start_tog_q;
            state_q      <= LS_DEV;
            shreg_q      <= {6'h00, i_sda_i};
            cnt_q        <= 4'h1;
            ack_q        <= 1'b0;
            armed_q      <= 1'b0;
        end
        else if (cnt_q == ACK_BIT_CNT)
        begin
            cnt_q <= 4'h0;
            ack_q <= 1'b0;
        end
        else if (state_q != LS_IDLE)
        begin
            cnt_q   <= cnt_q + 4'h1;
            shreg_q <= {shreg_q[5:0], i_sda_i};
            if (byte_done)
            begin
                unique case (state_q)
                    LS_IDLE:
                    begin
                        ack_q <= 1'b0;
                    end
                    LS_DEV:
                    begin
                        // no answer while the array is programming
                        if (dev_match(byte_w, straps_l) && !busy_l)
                        begin
                            ack_q   <= 1'b1;
                            // reads continue in the read path
                            state_q <= byte_w[RW_BIT] ? LS_IDLE : LS_ADDR_HI;
                        end
                        else
                        begin
                            ack_q   <= 1'b0;
                            state_q <= LS_IDLE;
                        end
                    end
                    LS_ADDR_HI:
                    begin
                        addr_hi_q <= byte_w[ADDR_HI_W-1:0];
                        ack_q     <= 1'b1;
                        state_q   <= LS_ADDR_LO;
                    end
                    LS_ADDR_LO:
                    begin
                        ack_q   <= 1'b1;
                        state_q <= LS_DATA;
                    end
                    LS_DATA:
                    begin
                        ack_q   <= 1'b1;
                        armed_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    // page buffer: words land at the in-page offset, which wraps
    always_ff @(posedge i_scl)
    begin
        if (!rst_l_n)
        begin
            page_q <= 9'h000;
            off_q  <= 6'h00;
            mask_q <= '0;
        end
        else if (byte_done && state_q == LS_ADDR_LO)
        begin
            page_q <= {addr_hi_q, byte_w[BYTE_W-1:OFF_W]};
            off_q  <= byte_w[OFF_W-1:0];
            mask_q <= '0;
        end
        else if (byte_done && state_q == LS_DATA)
        begin
            mask_q[off_q] <= 1'b1;
            off_q         <= off_q + 6'h01;
        end
    end

    always_ff @(posedge i_scl)
    begin
        if (byte_done && state_q == LS_DATA)
        begin
            buf_q[off_q] <= byte_w;
        end
    end

    // acknowledge goes out on the falling clock and is dropped on the next one
    always_ff @(negedge i_scl)
    begin
        if (!rst_l_n)
        begin
            sda_oe_q <= 1'b0;
        end
        else
        begin
            sda_oe_q <= (cnt_q == ACK_BIT_CNT) && ack_q;
        end
    end

    assign o_sda_oe = sda_oe_q;

    // framing events and write enables brought onto the system clock
    twe_sync #(.W(4)) u_sys_sync
    (
        .i_clk (i_clk_sys),
        .i_d   ({start_tog_q, stop_tog_q, armed_q, i_write_protect}),
        .o_q   ({start_s, stop_s, armed_s, wp_s})
    );

    assign start_ev = start_s ^ start_prev_q;
    assign stop_ev  = stop_s ^ stop_prev_q;

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            start_prev_q <= 1'b0;
            stop_prev_q  <= 1'b0;
        end
        else
        begin
            start_prev_q <= start_s;
            stop_prev_q  <= stop_s;
        end
    end

    // program cycle: copy the page, then hold busy for the rest of the time
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            prog_q <= SS_IDLE;
            busy_q <= 1'b0;
            tmr_q  <= 17'h00000;
            idx_q  <= 6'h00;
        end
        else
        begin
            unique case (prog_q)
                SS_IDLE:
                begin
                    // a stop after data starts the cycle unless protected
                    if (stop_ev && armed_s && !wp_s)
                    begin
                        prog_q <= SS_COPY;
                        busy_q <= 1'b1;
                        tmr_q  <= 17'h00000;
                        idx_q  <= 6'h00;
                    end
                end
                SS_COPY:
                begin
                    tmr_q <= tmr_q + 17'h00001;
                    idx_q <= idx_q + 6'h01;
                    if (idx_q == 6'(PAGE_BYTES - 1))
                    begin
                        prog_q <= SS_WAIT;
                    end
                end
                SS_WAIT:
                begin
                    tmr_q <= tmr_q + 17'h00001;
                    if (tmr_q == 17'(BUSY_CYC - 1))
                    begin
                        prog_q <= SS_IDLE;
                        busy_q <= 1'b0;
                    end
                end
                default:
                begin
                    prog_q <= SS_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    // page buffer is steady while busy: the link answers nothing until it ends
    always_ff @(posedge i_clk_sys)
    begin
        if (prog_q == SS_COPY && mask_q[idx_q])
        begin
            mem_q[{page_q, idx_q}] <= buf_q[idx_q];
        end
    end

    // standby once the frame is closed and the array is quiet
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            frame_open_q <= 1'b0;
            standby_q    <= 1'b1;
            sda_o_q      <= 1'b0;
        end
        else
        begin
            if (start_ev)
            begin
                frame_open_q <= 1'b1;
            end
            else if (stop_ev)
            begin
                frame_open_q <= 1'b0;
            end
            standby_q <= !frame_open_q && !busy_q;
            sda_o_q   <= 1'b0;
        end
    end

    assign o_sda_o     = sda_o_q;
    assign o_prog_busy = busy_q;
    assign o_standby   = standby_q;

endmodule

// File: sim/twe_target_monitor.sv
// Purpose: concurrent checks on the ports of the two-wire memory target
// Assumes: serial clock idles high between frames
// Notes:   bound into every twe_target instance
module twe_target_monitor
    import twe_pkg::*;
#(
    parameter int P_PROG_CYC = PROG_CYC
)
(
    input wire logic               i_clk_sys,
    input wire logic               i_rst_n,
    input wire logic               i_scl,
    input wire logic               i_sda_i,
    input wire logic [STRAP_W-1:0] i_chip_select_straps,
    input wire logic               i_write_protect,
    input wire logic               o_sda_o,
    input wire logic               o_sda_oe,
    input wire logic               o_prog_busy,
    input wire logic               o_standby
);
    timeunit 1ns;
    timeprecision 1ps;

    int busy_cnt_q;

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n || !o_prog_busy)
            busy_cnt_q <= 0;
        else
            busy_cnt_q <= busy_cnt_q + 1;
    end

    property p_ack_low;
        @(posedge i_clk_sys) disable iff (!i_rst_n) o_sda_oe |-> !o_sda_o;
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("ack not low");

    property p_ack_width;
        @(negedge i_scl) disable iff (!i_rst_n) $rose(o_sda_oe) |-> ##1 !o_sda_oe;
    endproperty
    a_ack_width: assert property (p_ack_width) else $error("ack too long");

    property p_ack_gap;
        @(negedge i_scl) disable iff (!i_rst_n) $rose(o_sda_oe) |-> ##1 (!o_sda_oe)[*8];
    endproperty
    a_ack_gap: assert property (p_ack_gap) else $error("ack before 8 bits");

    property p_no_ack_busy;
        @(posedge i_clk_sys) disable iff (!i_rst_n) o_prog_busy |-> !o_sda_oe;
    endproperty
    a_no_ack_busy: assert property (p_no_ack_busy) else $error("ack while busy");

    property p_busy_awake;
        @(posedge i_clk_sys) disable iff (!i_rst_n) o_prog_busy |-> !o_standby;
    endproperty
    a_busy_awake: assert property (p_busy_awake) else $error("standby while busy");

    property p_busy_end;
        @(posedge i_clk_sys) disable iff (!i_rst_n) $fell(o_prog_busy) |-> ##[0:2] o_standby;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("no standby after busy");

    property p_busy_len;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
            $fell(o_prog_busy) |-> busy_cnt_q == P_PROG_CYC - 3;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");

    property p_wp_block;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
            $rose(o_prog_busy) |-> $past(i_write_protect, 3) == 1'b0;
    endproperty
    a_wp_block: assert property (p_wp_block) else $error("busy under protect");

    property p_stop_cause;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
            $rose(o_prog_busy) |-> $past(i_sda_i, 2) && $past(i_scl, 2);
    endproperty
    a_stop_cause: assert property (p_stop_cause) else $error("busy without stop");
endmodule

bind twe_target twe_target_monitor #(.P_PROG_CYC(P_PROG_CYC)) u_mon (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda_i(i_sda_i),
    .i_chip_select_straps(i_chip_select_straps), .i_write_protect(i_write_protect),
    .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_prog_busy(o_prog_busy),
    .o_standby(o_standby));

// File: sim/twe_ctrl_model.sv
// Purpose: bus controller model making the serial clock and data level
// Assumes: 80 ns bit period; a released data line reads high by pull-up
// Notes:   the clock stands high between frames
module twe_ctrl_model
(
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    task automatic wiggle();
        o_scl = 1'b0;
        #20 o_sda = 1'b0;
        #20 o_sda = 1'b1;
        repeat (3)
        begin
            #20 o_scl = 1'b1;
            #20 o_scl = 1'b0;
        end
        #20 o_scl = 1'b1;
    endtask

    task automatic clk_bit(input logic b, output logic s);
        o_sda = b;
        #20 o_scl = 1'b1;
        #20 s = i_sda;
        #20 o_scl = 1'b0;
        #20;
    endtask

    task automatic start();
        o_sda = 1'b1;
        #20 o_scl = 1'b1;
        #20 o_sda = 1'b0;
        #20 o_scl = 1'b0;
        #20;
    endtask

    task automatic stop();
        o_sda = 1'b0;
        #20 o_scl = 1'b1;
        #20 o_sda = 1'b1;
        #40;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(b[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
    endtask
endmodule

// File: sim/twe_target_tb.sv
// Purpose: self-checking bench of the two-wire memory target write path
// Assumes: short program count; controller model makes the serial clock
// Notes:   no array read port here, so writes are judged by ack, busy and a hierarchical look at uut.mem_q
module twe_target_tb;
    import twe_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PC = 200;
    logic               clk_sys = 1'b0;
    logic               rst_n   = 1'b0;
    logic [STRAP_W-1:0] straps  = 3'h0;
    logic               wp      = 1'b0;
    logic               scl;
    logic               sda_ctl;
    logic               sda_o;
    logic               sda_oe;
    logic               busy;
    logic               stdby;
    logic               sda;
    int                 miscompares = 0;
    int                 checks_done = 0;

    assign sda = sda_oe ? sda_o : sda_ctl;
    always #25 clk_sys = ~clk_sys;

    twe_target #(.P_PROG_CYC(PC)) uut (
        .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_scl(scl), .i_sda_i(sda),
        .i_chip_select_straps(straps), .i_write_protect(wp), .o_sda_o(sda_o),
        .o_sda_oe(sda_oe), .o_prog_busy(busy), .o_standby(stdby));
    twe_ctrl_model u_ctl (.i_sda(sda), .o_scl(scl), .o_sda(sda_ctl));

    task automatic wrap_up();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk_bit(input string what, input logic e, input logic g);
        checks_done++;
        if (g !== e)
        begin
            $display("unexpected %s expected %b seen %b", what, e, g);
            miscompares++;
        end
    endtask

    task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            $display("unexpected %s expected %h seen %h", what, e, g);
            miscompares++;
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask

    task automatic drive(input logic [2:0] s, input logic w);
        settle(1);
        straps = s;
        wp = w;
    endtask

    task automatic wait_busy(input logic lvl, output int n);
        n = 0;
        while (busy !== lvl && n < 2 * PC)
        begin
            settle(1);
            n++;
        end
        if (n >= 2 * PC)
        begin
            $display("unexpected busy timeout expected %b seen %b", lvl, busy);
            miscompares++;
            wrap_up();
        end
    endtask

    task automatic word(input logic [7:0] w, input logic e, input string what);
        logic a;
        u_ctl.send_byte(w, a);
        chk_bit(what, e, a);
    endtask

    task automatic dev_frame(input logic [7:0] w, input logic e, input string what);
        u_ctl.start();
        word(w, e, what);
        u_ctl.stop();
        settle(10);
    endtask

    task automatic write_frame(input int n);
        u_ctl.start();
        word(8'ha4, 1'b1, "dev");
        word(8'h85, 1'b1, "addr hi");
        word(8'hfe, 1'b1, "addr lo");
        for (int i = 0; i < n; i++)
            word(8'(i * 37), 1'b1, "data");
        u_ctl.stop();
    endtask

    task automatic t_address();
        for (int s = 0; s < 8; s++)
        begin
            drive(3'(s), 1'b0);
            dev_frame({DEV_CODE, 3'(s), 1'b0}, 1'b1, "dev match");
            dev_frame({DEV_CODE, 3'(s ^ 1), 1'b0}, 1'b0, "strap miss");
            chk_bit("standby", 1'b1, stdby);
        end
        dev_frame({4'hb, 3'h7, 1'b0}, 1'b0, "code miss");
        dev_frame({DEV_CODE, 3'h7, 1'b1}, 1'b1, "dev read");
        chk_bit("busy", 1'b0, busy);
    endtask

    task automatic t_write(input int n);
        int  c;
        time t0;
        drive(3'h2, 1'b0);
        write_frame(n);
        t0 = $time;
        wait_busy(1'b1, c);
        chk_bit("busy rise", 1'b1, c <= 5);
        dev_frame(8'ha4, 1'b0, "poll busy");
        wait_busy(1'b0, c);
        chk_bit("program time", 1'b1, ($time - t0) <= PC * 50);
        dev_frame(8'ha4, 1'b1, "poll done");
        chk_bit("standby", 1'b1, stdby);
    endtask

    task automatic t_protect();
        drive(3'h2, 1'b1);
        write_frame(2);
        settle(20);
        chk_bit("busy protect", 1'b0, busy);
        drive(3'h2, 1'b0);
    endtask

    task automatic t_soft_reset();
        logic s;
        u_ctl.start();
        repeat (3) u_ctl.clk_bit(1'b0, s);
        u_ctl.start();
        repeat (9) u_ctl.clk_bit(1'b1, s);
        u_ctl.start();
        u_ctl.stop();
        settle(10);
        chk_bit("standby", 1'b1, stdby);
        dev_frame(8'ha4, 1'b1, "after recovery");
    endtask

    initial
    begin
        fork
            u_ctl.wiggle();
            repeat (6) @(posedge clk_sys);
        join
        #2;
        rst_n = 1'b1;
        u_ctl.wiggle();
        settle(4);
        chk_bit("standby", 1'b1, stdby);
        chk_bit("busy", 1'b0, busy);
        t_address();
        t_write(1);
        // word i of a frame at 0x05fe lands at offset (62 + i) mod 64 of that page
        chk_byte("byte write", 8'h00, uut.mem_q[15'h05fe]);
        t_write(66);
        chk_byte("page wrap", 8'h40, uut.mem_q[15'h05fe]);
        chk_byte("page end", 8'h65, uut.mem_q[15'h05ff]);
        chk_byte("page start", 8'h4a, uut.mem_q[15'h05c0]);
        t_protect();
        chk_byte("protected lo", 8'h40, uut.mem_q[15'h05fe]);
        chk_byte("protected hi", 8'h65, uut.mem_q[15'h05ff]);
        t_soft_reset();
        wrap_up();
    end
endmodule
